/* File: fep_defs.svh */
`ifndef FEP_DEFS_SVH
`define FEP_DEFS_SVH

// Code groups on the network side
`define FEP_SYM_IDLE    5'h1f
`define FEP_SYM_J       5'h18
`define FEP_SYM_K       5'h11
`define FEP_SYM_T       5'h0d
`define FEP_SYM_R       5'h07
`define FEP_SYM_H       5'h04
`define FEP_SYM_ZERO    5'h00

// Nibbles presented to the MAC
`define FEP_NIB_PRE     4'h5
`define FEP_NIB_ERR     4'he
`define FEP_NIB_ZERO    4'h0
`define FEP_NIB_ONES    4'hf

// Timing
`define FEP_CLK_MHZ     25
`define FEP_LINKUP_MS   50
`define FEP_LOCKWIN_MS  2
`define FEP_IDLE_RUN    4'hc
`define FEP_DRIB_MAXPAD 3'h4

// Register word offsets (byte address bits 7:2)
`define FEP_REG_CTRL    6'h00
`define FEP_REG_STAT    6'h01

// Control register fields
`define FEP_CTRL_RST    32'h0000_0001
`define FEP_CTRL_AN     0
`define FEP_CTRL_FIBER  1
`define FEP_CTRL_BYP    2
`define FEP_CTRL_OVR    3
`define FEP_CTRL_HDX    4
`define FEP_CTRL_W      5

// Scrambler seed
`define FEP_SCR_SEED    11'h7ff

`endif

/* File: fep_mac_model.sv */
`timescale 1ns/1ns
`default_nettype none

// MAC side of the transmit MII
module fep_mac_model
    import fep_pkg::*;
(
    // Clock
    input  wire logic       clk_sys,
    // Transmit group
    output var fep_mii_tx_t miiTx
);
    initial miiTx = '0;

    // Six-nibble frame, error on one index, driven after each rising edge
    task automatic send(input logic [3:0] nib [6], input int erAt);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk_sys);
            miiTx <= '{en: 1'b1, er: (i == erAt), d: nib[i]};
        end
        @(posedge clk_sys);
        miiTx <= '0;
    endtask

    // Gap set by the caller, never timed from carrier
endmodule

`default_nettype wire

/* File: fep_pcs.sv */
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "fep_defs.svh"

// Operation
// - Idle code groups while transmit enable low
// - Start of frame sends J then K
// - Encode remaining nibbles until enable drops
// - Nibbles map through fixed 4B/5B table
// - Frame end sends T then R
// - Transmit error sends H code group
// - Unknown code groups received inside a frame flag receive error
// - Received J/K become two preamble nibbles
// - Dribble bits: pad short, drop long
// - Link up after lock held 50 ms
// - Link down when 2 ms lacks idle run
// - Report link failure in status bits
// - Link failure restarts negotiation when enabled
// - Transmit frames only with link, unless override set without negotiation
// - Negotiation bursts while negotiating and link down
// - Carrier follows J/K and T/R pairs
// - Idle without T/R: one-cycle receive error
// - Valid flags decoded data, else zeros
// - Collision held while collision lasts
// - Scramble transmit, descramble receive symbols
// - Fiber only without negotiation, fiber selected
// - MII clocks are 25 MHz system clock
// - MII transmit sampled on rising edge
// - Invalid symbol drives nibble 1110
module fep_pcs
    import fep_pkg::*;
#(
    parameter int LINKUP_CYC  = `FEP_LINKUP_MS * 1000 * `FEP_CLK_MHZ,
    parameter int LOCKWIN_CYC = `FEP_LOCKWIN_MS * 1000 * `FEP_CLK_MHZ
)(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // MII
    input  wire fep_mii_tx_t miiTx,
    output fep_mii_rx_t      miiRx,
    // Line side
    output logic      [4:0]  lineTxSym,
    input  wire logic        lineRxClk,
    input  wire logic [4:0]  lineRxSym,
    input  wire logic [2:0]  lineRxDrib,
    // Link management
    output logic             linkUp,
    output logic             linkFail,
    output logic             anRestart,
    output logic             flpSend,
    output logic             fiberActive
);

    // Data nibble to code group
    function automatic logic [4:0] fepEncode(input logic [3:0] n);
        case (n)
            4'h0: fepEncode = 5'h1e;
            4'h1: fepEncode = 5'h09;
            4'h2: fepEncode = 5'h14;
            4'h3: fepEncode = 5'h15;
            4'h4: fepEncode = 5'h0a;
            4'h5: fepEncode = 5'h0b;
            4'h6: fepEncode = 5'h0e;
            4'h7: fepEncode = 5'h0f;
            4'h8: fepEncode = 5'h12;
            4'h9: fepEncode = 5'h13;
            4'ha: fepEncode = 5'h16;
            4'hb: fepEncode = 5'h17;
            4'hc: fepEncode = 5'h1a;
            4'hd: fepEncode = 5'h1b;
            4'he: fepEncode = 5'h1c;
            default: fepEncode = 5'h1d;
        endcase
    endfunction

    // Code group to {valid, nibble} by inverse search
    function automatic logic [4:0] fepDecode(input logic [4:0] s);
        fepDecode = 5'h00;
        for (int i = 0; i < 16; i++)
        begin
            if (fepEncode(4'(i)) == s)
                fepDecode = {1'b1, 4'(i)};
        end
    endfunction

    // Five steps of x^11 + x^9 + 1, newest key bits at the bottom
    function automatic logic [10:0] fepStep5(input logic [10:0] s);
        fepStep5 = s;
        for (int i = 0; i < 5; i++)
            fepStep5 = {fepStep5[9:0], fepStep5[10] ^ fepStep5[8]};
    endfunction

    logic [31:0] ctrl_r;
    logic        ack_r;
    logic        anEn, fiberSel, scrByp, ovr, hdx, byp;
    logic        linkUp_r, linkLatch_r, lock_r;
    logic        rxCarrier_r;
    logic        txBusy;
    logic        txAllowed;
    logic        regHit;
    logic [31:0] statWord;

    assign anEn      = ctrl_r[`FEP_CTRL_AN];
    assign fiberSel  = ctrl_r[`FEP_CTRL_FIBER];
    assign scrByp    = ctrl_r[`FEP_CTRL_BYP];
    assign ovr       = ctrl_r[`FEP_CTRL_OVR];
    assign hdx       = ctrl_r[`FEP_CTRL_HDX];
    assign fiberActive = fiberSel && !anEn;
    assign byp       = scrByp || fiberActive;
    assign txAllowed = linkUp_r || (ovr && !anEn);
    assign flpSend   = anEn && !linkUp_r;
    assign linkUp    = linkUp_r;

    // Wishbone: one wait state, unmapped words read zero
    assign regHit = cyc_i && stb_i && !ack_r;
    assign ack_o  = ack_r;
    assign statWord = {26'h0, fiberActive, miiRx.crs, txBusy, lock_r, linkLatch_r, linkUp_r};
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ack_r <= 1'b0;
            dat_o <= 32'h0;
        end
        else
        begin
            ack_r <= regHit;
            dat_o <= 32'h0;
            if (regHit && !we_i && adr_i[7:2] == `FEP_REG_CTRL)
                dat_o <= ctrl_r;
            else if (regHit && !we_i && adr_i[7:2] == `FEP_REG_STAT)
                dat_o <= statWord;
        end
    end

    // Control register, byte lane 0 holds every field
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            ctrl_r <= `FEP_CTRL_RST;
        else if (regHit && we_i && sel_i[0] && adr_i[7:2] == `FEP_REG_CTRL)
            ctrl_r <= {27'h0, dat_i[`FEP_CTRL_W-1:0]};
    end

    // Transmit path
    fep_tx_state_t txSt_r, txSt_nxt;
    logic [4:0]  txPlain_r, txPlain_nxt;
    logic [10:0] txScr_r, txScr_nxt;

    assign txBusy = (txSt_r != TX_IDLE);

    // Frame sequencing, MII sampled on the system clock rising edge
    always_comb
    begin
        txSt_nxt    = txSt_r;
        txPlain_nxt = `FEP_SYM_IDLE;
        case (txSt_r)
            TX_IDLE:
                if (miiTx.en && txAllowed)
                begin
                    txSt_nxt    = TX_J;
                    txPlain_nxt = `FEP_SYM_J;
                end
            TX_J:
            begin
                txSt_nxt    = TX_K;
                txPlain_nxt = `FEP_SYM_K;
            end
            TX_K, TX_DATA:
                if (miiTx.en)
                begin
                    txSt_nxt    = TX_DATA;
                    txPlain_nxt = miiTx.er ? `FEP_SYM_H : fepEncode(miiTx.d);
                end
                else
                begin
                    txSt_nxt    = TX_T;
                    txPlain_nxt = `FEP_SYM_T;
                end
            TX_T:
            begin
                txSt_nxt    = TX_R;
                txPlain_nxt = `FEP_SYM_R;
            end
            TX_R:
                txSt_nxt = TX_IDLE;
            default:
                txSt_nxt = TX_IDLE;
        endcase
    end

    // Scramble every transmitted code group
    assign txScr_nxt = fepStep5(txScr_r);
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            txSt_r    <= TX_IDLE;
            txPlain_r <= `FEP_SYM_IDLE;
            txScr_r   <= `FEP_SCR_SEED;
            lineTxSym <= `FEP_SYM_IDLE;
        end
        else
        begin
            txSt_r    <= txSt_nxt;
            txPlain_r <= txPlain_nxt;
            txScr_r   <= txScr_nxt;
            lineTxSym <= byp ? txPlain_nxt : (txPlain_nxt ^ txScr_nxt[4:0]);
        end
    end

    // Receive sampling
    logic       clkS1, clkS2, clkS3;
    logic [4:0] symS1, symS2;
    logic [2:0] drbS1, drbS2;
    logic       symStb_r;
    logic [4:0] rxSym_r;
    logic [2:0] rxDrib_r;

    // Two-stage synchronisers, edge found after the second stage
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            {clkS1, clkS2, clkS3} <= 3'h0;
            {symS1, symS2} <= 10'h0;
            {drbS1, drbS2} <= 6'h0;
            symStb_r <= 1'b0;
            rxSym_r  <= `FEP_SYM_IDLE;
            rxDrib_r <= 3'h0;
        end
        else
        begin
            clkS1 <= lineRxClk;
            clkS2 <= clkS1;
            clkS3 <= clkS2;
            symS1 <= lineRxSym;
            symS2 <= symS1;
            drbS1 <= lineRxDrib;
            drbS2 <= drbS1;
            symStb_r <= clkS2 && !clkS3;
            if (clkS2 && !clkS3)
            begin
                rxSym_r  <= symS2;
                rxDrib_r <= drbS2;
            end
        end
    end

    // Descrambler
    logic [10:0] rxScr_r, rxScrStep;
    logic [4:0]  dSym;
    logic        dIdle;

    assign rxScrStep = fepStep5(rxScr_r);
    assign dSym  = byp ? rxSym_r : (rxSym_r ^ rxScrStep[4:0]);
    assign dIdle = (dSym == `FEP_SYM_IDLE);
    // Until locked, reload key state assuming the line carries idle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            rxScr_r <= `FEP_SCR_SEED;
        else if (symStb_r)
            rxScr_r <= lock_r ? rxScrStep : {rxScr_r[5:0], ~rxSym_r};
    end

    // Lock and link
    logic [3:0]  idleRun_r;
    logic        winHit_r;
    logic [15:0] winCnt_r;
    logic [20:0] upCnt_r;
    logic        runDone;

    // Run of twelve idles, still true while the run lasts so each window sees it
    assign runDone = symStb_r && dIdle && (idleRun_r >= `FEP_IDLE_RUN - 4'h1);
    // Idle run counter and window check
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            idleRun_r <= 4'h0;
            winHit_r  <= 1'b0;
            winCnt_r  <= 16'h0;
            lock_r    <= 1'b0;
        end
        else
        begin
            if (symStb_r)
                idleRun_r <= !dIdle ? 4'h0 :
                             (idleRun_r == `FEP_IDLE_RUN) ? idleRun_r : idleRun_r + 4'h1;
            if (winCnt_r == 16'(LOCKWIN_CYC - 1))
            begin
                winCnt_r <= 16'h0;
                winHit_r <= 1'b0;
                lock_r   <= winHit_r || runDone;
            end
            else
            begin
                winCnt_r <= winCnt_r + 16'h1;
                if (runDone)
                begin
                    winHit_r <= 1'b1;
                    lock_r   <= 1'b1;
                end
            end
        end
    end

    // Link qualification timer and failure events
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            upCnt_r     <= 21'h0;
            linkUp_r    <= 1'b0;
            linkLatch_r <= 1'b0;
            linkFail    <= 1'b0;
            anRestart   <= 1'b0;
        end
        else
        begin
            linkFail  <= linkUp_r && !lock_r;
            anRestart <= linkUp_r && !lock_r && anEn;
            if (!lock_r)
            begin
                upCnt_r  <= 21'h0;
                linkUp_r <= 1'b0;
            end
            else if (upCnt_r == 21'(LINKUP_CYC - 1))
                linkUp_r <= 1'b1;
            else
                upCnt_r <= upCnt_r + 21'h1;
            // Failure wins over the status-read re-arm
            if (linkUp_r && !lock_r)
                linkLatch_r <= 1'b0;
            else if (regHit && !we_i && adr_i[7:2] == `FEP_REG_STAT)
                linkLatch_r <= linkUp_r;
        end
    end

    // Receive framing
    fep_rx_state_t rxSt_r;
    logic [4:0] dDec;
    logic [3:0] pend_r;
    logic       pendV_r, preQ_r;
    logic [3:0] padMask;

    assign dDec = fepDecode(dSym);
    assign padMask = 4'(4'hf << rxDrib_r);
    // Held-back nibble lets the trailing partial one be padded or dropped
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rxSt_r      <= RX_IDLE;
            rxCarrier_r <= 1'b0;
            pend_r      <= `FEP_NIB_ZERO;
            pendV_r     <= 1'b0;
            preQ_r      <= 1'b0;
            miiRx.crs   <= 1'b0;
            miiRx.col   <= 1'b0;
            miiRx.dv    <= 1'b0;
            miiRx.er    <= 1'b0;
            miiRx.d     <= `FEP_NIB_ZERO;
        end
        else
        begin
            miiRx.dv <= 1'b0;
            miiRx.er <= 1'b0;
            miiRx.d  <= `FEP_NIB_ZERO;
            preQ_r   <= 1'b0;
            // Carrier and collision; MII runs on this 25 MHz clock
            miiRx.crs <= rxCarrier_r || (hdx && txBusy);
            miiRx.col <= hdx && txBusy && rxCarrier_r;
            if (preQ_r)
            begin
                miiRx.dv <= 1'b1;
                miiRx.d  <= `FEP_NIB_PRE;
            end
            else if (symStb_r)
            begin
                case (rxSt_r)
                    RX_IDLE:
                        if (dSym == `FEP_SYM_J)
                            rxSt_r <= RX_K;
                    RX_K:
                        if (dSym == `FEP_SYM_K)
                        begin
                            rxSt_r      <= RX_DATA;
                            rxCarrier_r <= 1'b1;
                            miiRx.dv    <= 1'b1;
                            miiRx.d     <= `FEP_NIB_PRE;
                            preQ_r      <= 1'b1;
                        end
                        else
                            rxSt_r <= RX_IDLE;
                    RX_DATA:
                        if (dSym == `FEP_SYM_T)
                            rxSt_r <= RX_T;
                        else if (dIdle)
                        begin
                            rxSt_r      <= RX_IDLE;
                            rxCarrier_r <= 1'b0;
                            pendV_r     <= 1'b0;
                            miiRx.er    <= 1'b1;
                        end
                        else if (dDec[4])
                        begin
                            pend_r   <= dDec[3:0];
                            pendV_r  <= 1'b1;
                            miiRx.dv <= pendV_r;
                            miiRx.d  <= pendV_r ? pend_r : `FEP_NIB_ZERO;
                        end
                        else
                        begin
                            miiRx.dv <= 1'b1;
                            miiRx.er <= 1'b1;
                            miiRx.d  <= `FEP_NIB_ERR;
                        end
                    RX_T:
                    begin
                        rxSt_r      <= RX_IDLE;
                        rxCarrier_r <= 1'b0;
                        pendV_r     <= 1'b0;
                        if (dSym != `FEP_SYM_R)
                            miiRx.er <= 1'b1;
                        else if (pendV_r && rxDrib_r <= `FEP_DRIB_MAXPAD)
                        begin
                            miiRx.dv <= 1'b1;
                            miiRx.d  <= (rxDrib_r == 3'h0) ? pend_r : (pend_r | padMask);
                        end
                    end
                    default:
                        rxSt_r <= RX_IDLE;
                endcase
            end
        end
    end

    a_idle_fill: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (txSt_r == TX_IDLE && !(miiTx.en && txAllowed)) |=> txPlain_r == `FEP_SYM_IDLE)
        else $error("idle not sent");
    a_ssd_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (txSt_r == TX_IDLE && miiTx.en && txAllowed) |=> txPlain_r == `FEP_SYM_J
        ##1 txPlain_r == `FEP_SYM_K)
        else $error("start pair wrong");
    a_esd_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($fell(miiTx.en) && txSt_r == TX_DATA) |=> txPlain_r == `FEP_SYM_T
        ##1 txPlain_r == `FEP_SYM_R ##1 txPlain_r == `FEP_SYM_IDLE)
        else $error("end pair wrong");
    a_tx_error: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (txSt_r == TX_DATA && miiTx.en && miiTx.er) |=> txPlain_r == `FEP_SYM_H)
        else $error("error code missing");
    a_rx_invalid: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (miiRx.er && miiRx.dv) |-> miiRx.d == `FEP_NIB_ERR)
        else $error("invalid nibble wrong");
    a_rxd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !miiRx.dv |-> miiRx.d == `FEP_NIB_ZERO)
        else $error("data not zero");
    a_link_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (linkUp_r && !lock_r) |=> !linkUp_r && linkFail && (anRestart == anEn))
        else $error("link not dropped");
    a_flp_down: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (anEn && !linkUp_r && !txBusy) |-> flpSend && txSt_nxt == TX_IDLE)
        else $error("bursts not sent");
    a_col_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (hdx && txBusy && rxCarrier_r)[*2] |=> miiRx.col)
        else $error("collision not held");
    a_false_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (symStb_r && rxSt_r == RX_DATA && dIdle) |=> miiRx.er && !rxCarrier_r
        ##1 !miiRx.er)
        else $error("false end not flagged");

endmodule
`default_nettype wire

/* File: fep_pkg.sv */
`default_nettype none

package fep_pkg;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_J    = 3'b001,
        TX_K    = 3'b010,
        TX_DATA = 3'b011,
        TX_T    = 3'b100,
        TX_R    = 3'b101
    } fep_tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_K    = 2'b01,
        RX_DATA = 2'b10,
        RX_T    = 2'b11
    } fep_rx_state_t;

    // MAC to device transmit group
    typedef struct packed {
        logic       en;
        logic       er;
        logic [3:0] d;
    } fep_mii_tx_t;

    // Device to MAC receive group
    typedef struct packed {
        logic       dv;
        logic       er;
        logic [3:0] d;
        logic       crs;
        logic       col;
    } fep_mii_rx_t;

endpackage

`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_top
    import fep_pkg::*;
;
    logic        clk_sys, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, lineRxClk = 0;
    logic [7:0]  adr = 0;
    logic [31:0] datI = 0, datO;
    logic [4:0]  lineTxSym, lineRxSym = 5'h1f;
    logic [2:0]  lineRxDrib = 0, ph = 0;
    logic        linkUp, linkFail, anRestart, flpSend, fiberActive;
    fep_mii_tx_t miiTx;
    fep_mii_rx_t miiRx;
    logic [7:0]  symQ [$];
    logic [3:0]  rxQ [$];
    int          num_errors = 0, cmp_count = 0, erCnt, badZero = 0, tick = 0;
    bit          sawFail, sawRst, sawCrs, sawCol;

    fep_pcs #(.LINKUP_CYC(200), .LOCKWIN_CYC(400)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(datI),
        .dat_o(datO), .ack_o(ack), .miiTx(miiTx), .miiRx(miiRx), .lineTxSym(lineTxSym),
        .lineRxClk(lineRxClk), .lineRxSym(lineRxSym), .lineRxDrib(lineRxDrib),
        .linkUp(linkUp), .linkFail(linkFail), .anRestart(anRestart), .flpSend(flpSend),
        .fiberActive(fiberActive));
    fep_mac_model i_mac (.clk_sys(clk_sys), .miiTx(miiTx));

    // Clock
    initial
    begin
        clk_sys = 0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Line symbols at 320 ns, idle fill when queue empty
    always @(posedge clk_sys)
    begin
        ph <= ph + 3'h1;
        lineRxClk <= ph[2];
        if (ph == 3'h1)
            {lineRxDrib, lineRxSym} <= symQ.size() ? symQ.pop_front() : 8'h1f;
    end

    // Receive monitor and timeout
    always @(posedge clk_sys)
    begin
        if (miiRx.dv === 1'b1) rxQ.push_back(miiRx.d);
        else if (miiRx.d !== 4'h0) badZero++;
        if (miiRx.er === 1'b1) erCnt++;
        if (miiRx.crs === 1'b1) sawCrs = 1;
        if (miiRx.col === 1'b1) sawCol = 1;
        if (linkFail === 1'b1) sawFail = 1;
        if (anRestart === 1'b1) sawRst = 1;
        tick++;
        if (tick == 30000)
        begin
            num_errors++;
            test_done();
        end
    end

    // Compare one value
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // Classic Wishbone single cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        {cyc, stb, we, adr, datI} <= {2'b11, w, a, d};
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 100);
        q = datO;
        chk("ack", 1, ack);
        {cyc, stb} <= 2'b00;
    endtask

    // Wait until queued line symbols are sent
    task automatic drain();
        int n;
        n = 0;
        while (symQ.size() != 0 && n < 3000)
        begin
            @(posedge clk_sys);
            n++;
        end
        repeat (50) @(posedge clk_sys);
    endtask

    task automatic t_link();
        logic [31:0] q;
        int n;
        wb(1, 8'h00, 32'h05, q);
        n = 0;
        while (linkUp !== 1'b1 && n < 3000)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk("link up", 1, linkUp);
        chk("link hold", 1, n >= 200);
        chk("no bursts", 0, flpSend);
        wb(0, 8'h04, 0, q);
        chk("stat first", 3'h5, q[2:0]);
        wb(0, 8'h04, 0, q);
        chk("stat", 3'h7, q[2:0]);
        repeat (900) @(posedge clk_sys);
        chk("link kept", 1, linkUp);
        {sawFail, sawRst} = 2'b00;
        repeat (120) symQ.push_back(8'h1e);
        drain();
        chk("link down", 0, linkUp);
        chk("fail pulse", 1, sawFail);
        chk("restart", 1, sawRst);
        chk("bursts", 1, flpSend);
        wb(0, 8'h04, 0, q);
        chk("stat latch", 0, q[1]);
        wb(0, 8'h10, 0, q);
        chk("unmapped", 0, q);
        wb(1, 8'h00, 32'h03, q);
        chk("fiber an", 0, fiberActive);
        wb(1, 8'h00, 32'h0e, q);
        chk("fiber", 1, fiberActive);
        wb(1, 8'h00, 32'h0c, q);
        $display("test link done");
    endtask

    task automatic t_tx();
        logic [4:0] e [9] = '{5'h18, 5'h11, 5'h1e, 5'h09, 5'h1d, 5'h04, 5'h0d, 5'h07, 5'h1f};
        int n;
        #1 chk("tx idle", 5'h1f, lineTxSym);
        fork
            i_mac.send('{4'h5, 4'h5, 4'h0, 4'h1, 4'hf, 4'h7}, 5);
            begin
                n = 0;
                while (lineTxSym !== 5'h18 && n < 50)
                begin
                    @(posedge clk_sys);
                    #1 n++;
                end
                for (int i = 0; i < 9; i++)
                begin
                    chk("tx sym", e[i], lineTxSym);
                    @(posedge clk_sys);
                    #1;
                end
            end
        join
        $display("test tx done");
    endtask

    task automatic t_rx(input logic [7:0] s [$], input logic [3:0] e [$], input int eEr);
        rxQ.delete();
        erCnt = 0;
        sawCrs = 0;
        symQ = s;
        drain();
        chk("rx count", e.size(), rxQ.size());
        foreach (e[i]) chk("rx nib", e[i], (i < rxQ.size()) ? rxQ[i] : 4'hx);
        chk("rx er", eEr, erCnt);
        chk("crs seen", 1, sawCrs);
        chk("crs end", 0, miiRx.crs);
        chk("rx zeros", 0, badZero);
        $display("test rx done");
    endtask

    task automatic t_col();
        logic [31:0] q;
        wb(1, 8'h00, 32'h1c, q);
        sawCol = 0;
        symQ = '{8'h18, 8'h11, 8'h1e, 8'h1e, 8'h1e, 8'h1e, 8'h1e, 8'h1e, 8'h0d, 8'h07};
        repeat (40) @(posedge clk_sys);
        i_mac.send('{4'h5, 4'h5, 4'h1, 4'h2, 4'h3, 4'h4}, -1);
        drain();
        chk("col seen", 1, sawCol);
        chk("col end", 0, miiRx.col);
        $display("test col done");
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1;
        @(posedge clk_sys);
        #1 chk("reset sym", 5'h1f, lineTxSym);
        chk("reset bursts", 1, flpSend);
        t_link();
        t_tx();
        t_rx('{8'h18, 8'h11, 8'h15, 8'h09, 8'h4d, 8'h47}, '{5, 5, 3, 4'hd}, 0);
        t_rx('{8'h18, 8'h11, 8'h13, 8'h0e, 8'hcd, 8'hc7}, '{5, 5, 9}, 0);
        t_rx('{8'h18, 8'h11, 8'h14, 8'h1f}, '{5, 5}, 1);
        t_rx('{8'h18, 8'h11, 8'h19, 8'had, 8'ha7}, '{5, 5, 4'he}, 1);
        t_col();
        test_done();
    end
endmodule

`default_nettype wire
